// ---- dca_top.sv ----
// dma channel address, count and status registers with the block engine
`timescale 1ns/10ps
module dca_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic ram_req,
  output logic ram_we,
  output logic [dca_pkg::RAM_AW-1:0] ram_addr,
  output logic [dca_pkg::DW-1:0] ram_wdata,
  input wire logic ram_ready,
  input wire logic [dca_pkg::DW-1:0] ram_rdata,
  output logic per_req,
  output logic per_we,
  output logic [dca_pkg::PAD_W-1:0] per_addr,
  output logic [dca_pkg::DW-1:0] per_wdata,
  input wire logic per_ready,
  input wire logic per_busy,
  input wire logic [dca_pkg::DW-1:0] per_rdata
);
  import dca_pkg::*;

  typedef struct packed {
    logic [NCH-1:0] en;
    logic [NCH-1:0] dir;
    logic [NCH-1:0] done;
    logic [NCH-1:0] coll;
    logic [NCH-1:0][PAD_W-1:0] pad;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0][RAM_AW-1:0] base;
    logic [RAM_AW-1:0] last;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic hready;
    logic hresp;
    logic busy;
    logic [CH_W-1:0] ch;
    dca_rd_st_t rst;
    dca_wr_st_t wst;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] wr_word;
    logic ram_req;
    logic ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [DW-1:0] ram_wdata;
    logic per_req;
    logic per_we;
    logic [PAD_W-1:0] per_addr;
    logic [DW-1:0] per_wdata;
  } dca_top_st_t;

  dca_top_st_t q;
  dca_top_st_t n;
  dca_fifo_if #(.W(DW)) fq ();
  logic ld;
  logic rd_step;
  logic wr_step;
  logic [CNT_W-1:0] rd_idx;
  logic [CNT_W-1:0] wr_idx;
  logic rd_last;
  logic wr_last;

  // register decode, shared by the read path and the write path
  function automatic dca_reg_t reg_kind(input logic [31:0] a);
    dca_reg_t k;
    k = RK_NONE;
    if (a[31:8] != 24'h000000 || a[1:0] != 2'b00) begin
      k = RK_NONE;
    end else if (a[7:0] < 8'(CH_SPAN * NCH)) begin
      if (a[3:0] == OFF_CTRL) begin
        k = RK_CTRL;
      end else if (a[3:0] == OFF_PAD) begin
        k = RK_PAD;
      end else if (a[3:0] == OFF_CNT) begin
        k = RK_CNT;
      end else begin
        k = RK_BASE;
      end
    end else if (a[7:0] == OFF_LAST_HI) begin
      k = RK_LAST_HI;
    end else if (a[7:0] == OFF_LAST_LO) begin
      k = RK_LAST_LO;
    end else if (a[7:0] == OFF_COLL || a[7:0] == OFF_STAT) begin
      k = RK_COLL_STAT;
    end
    return k;
  endfunction

  // read value of one register; unmapped space reads as zero
  function automatic logic [31:0] reg_read(input dca_top_st_t s,
                                            input logic [31:0] a);
    logic [31:0] v;
    logic [CH_W-1:0] c;
    v = 32'h00000000;
    c = a[5:4];
    case (reg_kind(a))
      RK_CTRL: begin
        v[CTRL_EN_BIT] = s.en[c];
        v[CTRL_DIR_BIT] = s.dir[c];
      end
      RK_PAD: v[PAD_W-1:0] = s.pad[c];
      RK_CNT: v[CNT_W-1:0] = s.cnt[c];
      RK_BASE: v[RAM_AW-1:0] = s.base[c];
      RK_LAST_HI: v[7:0] = s.last[23:16];
      RK_LAST_LO: v[15:0] = s.last[15:0];
      RK_COLL_STAT: begin
        if (a[7:0] == OFF_COLL) begin
          v[NCH-1:0] = s.coll;
        end else begin
          v[STAT_DONE_LSB +: NCH] = s.done;
          v[STAT_BUSY_BIT] = s.busy;
          v[STAT_CH_LSB +: CH_W] = s.ch;
        end
      end
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  // data buffer between the source read and the destination write
  dca_fifo #(
    .W(DW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .fq(fq.fifo_side)
  );

  // read side and write side each walk count plus one words
  dca_step_cnt u_rd_cnt (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(ld),
    .limit(n.cnt[n.ch]),
    .step(rd_step),
    .idx(rd_idx),
    .last(rd_last)
  );

  dca_step_cnt u_wr_cnt (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(ld),
    .limit(n.cnt[n.ch]),
    .step(wr_step),
    .idx(wr_idx),
    .last(wr_last)
  );

  // fifo handshakes follow the engine states directly
  assign fq.push_valid = (q.rst == RD_PUSH);
  assign fq.push_data = q.rd_word;
  assign fq.pop_ready = (q.wst == WR_WAIT);

  // outputs come straight from the state flops
  assign hreadyout = q.hready;
  assign hresp = q.hresp;
  assign hrdata = q.rdata;
  assign ram_req = q.ram_req;
  assign ram_we = q.ram_we;
  assign ram_addr = q.ram_addr;
  assign ram_wdata = q.ram_wdata;
  assign per_req = q.per_req;
  assign per_we = q.per_we;
  assign per_addr = q.per_addr;
  assign per_wdata = q.per_wdata;

  always_comb begin
    logic src_ram;
    logic rd_ack;
    logic wr_ack;
    logic issue_rd;
    logic issue_wr;
    logic found;
    logic [CH_W-1:0] pick;
    logic [CNT_W-1:0] rd_off;
    logic [CH_W-1:0] wc;
    src_ram = q.dir[q.ch];
    rd_ack = 1'b0;
    wr_ack = 1'b0;
    issue_rd = 1'b0;
    issue_wr = 1'b0;
    found = 1'b0;
    pick = '0;
    rd_off = '0;
    wc = q.wr_addr[5:4];
    n = q;
    ld = 1'b0;
    rd_step = 1'b0;
    wr_step = 1'b0;

    // data phase of a bus write; zero wait states, always okay
    n.hready = 1'b1;
    n.hresp = 1'b0;
    n.wr_pend = 1'b0;
    if (q.wr_pend) begin
      case (reg_kind(q.wr_addr))
        RK_CTRL: begin
          n.en[wc] = hwdata[CTRL_EN_BIT];
          n.dir[wc] = hwdata[CTRL_DIR_BIT];
          n.done[wc] = 1'b0;
          n.coll[wc] = 1'b0;
        end
        // taken as written even while enabled; software avoids that
        RK_PAD: n.pad[wc] = hwdata[PAD_W-1:0];
        RK_CNT: n.cnt[wc] = hwdata[CNT_W-1:0];
        RK_BASE: n.base[wc] = hwdata[RAM_AW-1:0];
        default: n.wr_pend = 1'b0;
      endcase
    end

    // a request drops in the cycle after its port accepts it
    if (q.ram_req && ram_ready) begin
      n.ram_req = 1'b0;
      n.last = q.ram_addr;
    end
    if (q.per_req && per_ready) begin
      n.per_req = 1'b0;
    end
    if (q.busy) begin
      rd_ack = src_ram ? (q.ram_req && ram_ready) : (q.per_req && per_ready);
      wr_ack = src_ram ? (q.per_req && per_ready) : (q.ram_req && ram_ready);
    end

    // lowest enabled channel wins; one block runs at a time
    if (!q.busy) begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (q.en[i]) begin
          found = 1'b1;
          pick = CH_W'(i);
        end
      end
      if (found) begin
        n.busy = 1'b1;
        n.ch = pick;
        ld = 1'b1;
        issue_rd = 1'b1;
        n.rst = RD_REQ;
        n.wst = WR_WAIT;
      end
    end

    // read half: fetch a word from the source, then push it
    case (q.rst)
      RD_REQ: begin
        if (rd_ack) begin
          n.rd_word = src_ram ? ram_rdata : per_rdata;
          n.rst = RD_PUSH;
        end
      end
      RD_PUSH: begin
        if (fq.push_ready) begin
          rd_step = 1'b1;
          if (rd_last) begin
            n.rst = RD_DONE;
          end else begin
            issue_rd = 1'b1;
            rd_off = CNT_W'(rd_idx + 1'b1);
            n.rst = RD_REQ;
          end
        end
      end
      default: n.rst = n.rst;
    endcase

    // write half: pop a word, then write it to the destination
    case (q.wst)
      WR_WAIT: begin
        if (fq.pop_valid) begin
          n.wr_word = fq.pop_data;
          issue_wr = 1'b1;
          n.wst = WR_REQ;
        end
      end
      WR_REQ: begin
        if (wr_ack) begin
          wr_step = 1'b1;
          n.wst = wr_last ? WR_DONE : WR_WAIT;
        end
      end
      default: n.wst = n.wst;
    endcase

    // source reads: ram walks up from the base, peripheral stays fixed
    if (issue_rd) begin
      if (n.dir[n.ch]) begin
        n.ram_req = 1'b1;
        n.ram_we = 1'b0;
        n.ram_addr = RAM_AW'(n.base[n.ch] + RAM_AW'(rd_off));
      end else begin
        n.per_req = 1'b1;
        n.per_we = 1'b0;
        n.per_addr = n.pad[n.ch];
      end
    end

    // destination writes; a peripheral still busy marks a collision
    if (issue_wr) begin
      if (src_ram) begin
        n.per_req = 1'b1;
        n.per_we = 1'b1;
        n.per_addr = q.pad[q.ch];
        n.per_wdata = fq.pop_data;
        if (per_busy) begin
          n.coll[q.ch] = 1'b1;
        end
      end else begin
        n.ram_req = 1'b1;
        n.ram_we = 1'b1;
        n.ram_addr = RAM_AW'(q.base[q.ch] + RAM_AW'(wr_idx));
        n.ram_wdata = fq.pop_data;
      end
    end

    // both halves finished: channel disables itself and flags done
    if (q.rst == RD_DONE && q.wst == WR_DONE) begin
      n.busy = 1'b0;
      n.en[q.ch] = 1'b0;
      n.done[q.ch] = 1'b1;
      n.rst = RD_IDLE;
      n.wst = WR_IDLE;
    end

    // address phase; read sees this cycle's updates, so no stale data
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        n.wr_pend = 1'b1;
        n.wr_addr = haddr;
      end else begin
        n.rdata = reg_read(n, haddr);
      end
    end
  end

  // single register stage for all block state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
      q.pad <= {NCH{PAD_RST}};
      q.cnt <= {NCH{CNT_RST}};
      q.last <= LAST_RST;
      q.hready <= 1'b1;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- dca_pkg.sv ----
// constants, register map and state types of the dma channel block
package dca_pkg;
  // channel count and datapath widths
  localparam int NCH = 4;
  localparam int CH_W = 2;
  localparam int CNT_W = 14;
  localparam int PAD_W = 16;
  localparam int RAM_AW = 24;
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 16;

  // channel registers repeat every CH_SPAN bytes from byte 0x00
  localparam logic [7:0] CH_SPAN = 8'h10;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_PAD = 4'h4;
  localparam logic [3:0] OFF_CNT = 4'h8;
  localparam logic [3:0] OFF_BASE = 4'hc;
  localparam logic [7:0] OFF_LAST_HI = 8'h40;
  localparam logic [7:0] OFF_LAST_LO = 8'h44;
  localparam logic [7:0] OFF_COLL = 8'h48;
  localparam logic [7:0] OFF_STAT = 8'h4c;

  // control and status field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int STAT_DONE_LSB = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_CH_LSB = 5;

  // values after reset
  localparam logic [PAD_W-1:0] PAD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
  localparam logic [RAM_AW-1:0] LAST_RST = 24'h000000;

  typedef enum logic [2:0] {
    RK_NONE, RK_CTRL, RK_PAD, RK_CNT, RK_BASE,
    RK_LAST_HI, RK_LAST_LO, RK_COLL_STAT
  } dca_reg_t;
  typedef enum logic [1:0] {RD_IDLE, RD_REQ, RD_PUSH, RD_DONE} dca_rd_st_t;
  typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_REQ, WR_DONE} dca_wr_st_t;
endpackage

// ---- dca_fifo_if.sv ----
// word stream between the read and write halves of the engine
`timescale 1ns/10ps
interface dca_fifo_if #(parameter int W = 16);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fifo_side (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user_side (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

// ---- dca_fifo.sv ----
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module dca_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  dca_fifo_if.fifo_side fq
);
  import dca_pkg::*;
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dca_fifo_st_t;
  dca_fifo_st_t q;
  dca_fifo_st_t n;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign fq.push_ready = (q.cnt != (AW+1)'(D));
  assign fq.pop_valid = (q.cnt != '0);
  assign fq.pop_data = q.mem[q.rp];
  assign push = fq.push_valid && fq.push_ready;
  assign pop = fq.pop_valid && fq.pop_ready;

  // pointers wrap at the depth, which need not be a power of two
  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = fq.push_data;
      n.wp = (q.wp == AW'(D - 1)) ? '0 : AW'(q.wp + 1'b1);
    end
    if (pop) begin
      n.rp = (q.rp == AW'(D - 1)) ? '0 : AW'(q.rp + 1'b1);
    end
    n.cnt = (AW+1)'(q.cnt + {AW'(0), push} - {AW'(0), pop});
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- dca_step_cnt.sv ----
// transfer index counter that knows the last of count plus one steps
`timescale 1ns/10ps
module dca_step_cnt (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [dca_pkg::CNT_W-1:0] limit,
  input wire logic step,
  output logic [dca_pkg::CNT_W-1:0] idx,
  output logic last
);
  import dca_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] idx;
    logic [CNT_W-1:0] lim;
  } dca_cnt_st_t;
  dca_cnt_st_t q;
  dca_cnt_st_t n;

  // index runs 0..limit, so limit 0 still gives one transfer
  assign idx = q.idx;
  assign last = (q.idx == q.lim);

  always_comb begin
    n = q;
    if (load) begin
      n.idx = '0;
      n.lim = limit;
    end else if (step) begin
      n.idx = CNT_W'(q.idx + 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// ---- dca_properties.sv ----
// concurrent checks on the ports of the dma channel block
`timescale 1ns/10ps
module dca_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic ram_req,
  input wire logic ram_ready,
  input wire logic [dca_pkg::RAM_AW-1:0] ram_addr,
  input wire logic per_req,
  input wire logic per_ready,
  input wire logic per_we,
  input wire logic [dca_pkg::PAD_W-1:0] per_addr
);
  import dca_pkg::*;
  logic take;
  logic rd_cnt_q, rd_hi_q, rd_lo_q, rd_col_q;
  logic [RAM_AW-1:0] last_q, snap_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  assign take = hsel && htrans[1] && hready && !hwrite;
  // shadow of the last ram accept; a read sees an accept at its own edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_cnt_q <= 1'b0;
      rd_hi_q <= 1'b0;
      rd_lo_q <= 1'b0;
      rd_col_q <= 1'b0;
      last_q <= '0;
      snap_q <= '0;
    end else begin
      rd_cnt_q <= take && haddr[7:6] == 2'b00 && haddr[3:0] == OFF_CNT;
      rd_hi_q <= take && haddr[7:0] == OFF_LAST_HI;
      rd_lo_q <= take && haddr[7:0] == OFF_LAST_LO;
      rd_col_q <= take && haddr[7:0] == OFF_COLL;
      if (take)
        snap_q <= (ram_req && ram_ready) ? ram_addr : last_q;
      if (ram_req && ram_ready)
        last_q <= ram_addr;
    end
  end
  chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not ready and okay");
  chk_cnt_top_zero: assert property (rd_cnt_q |-> hrdata[31:14] == '0)
    else $error("count upper bits not zero");
  chk_last_hi_read: assert property (rd_hi_q |->
    hrdata == {24'h0, snap_q[23:16]}) else $error("last address high wrong");
  chk_last_lo_read: assert property (rd_lo_q |->
    hrdata == {16'h0, snap_q[15:0]}) else $error("last address low wrong");
  chk_coll_field: assert property (rd_col_q |-> hrdata[31:4] == '0)
    else $error("collision register upper bits set");
  chk_ram_req_hold: assert property (ram_req && !ram_ready |=>
    ram_req && $stable(ram_addr)) else $error("ram request not held");
  chk_per_req_hold: assert property (per_req && !per_ready |=> per_req &&
    $stable(per_addr) && $stable(per_we)) else $error("peripheral request moved");
  chk_ram_req_drop: assert property (ram_req && ram_ready |=> !ram_req)
    else $error("ram request stays after accept");
  cover property (ram_req && ram_ready);
  cover property (per_req && per_ready && per_we);
  cover property (rd_col_q && hrdata[3:0] != 4'h0);
endmodule
bind dca_top dca_properties dca_properties_i (.clock, .sys_rst, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .ram_req,
  .ram_ready, .ram_addr, .per_req, .per_ready, .per_we, .per_addr);

// ---- dca_partner.sv ----
// behavioural ram and peripheral answering the engine's requests
`timescale 1ns/10ps
module dca_partner (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic busy_on,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic [23:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  output logic ram_ready,
  output logic [15:0] ram_rdata,
  input wire logic per_req,
  input wire logic per_we,
  input wire logic [15:0] per_addr,
  input wire logic [15:0] per_wdata,
  output logic per_ready,
  output logic per_busy,
  output logic [15:0] per_rdata,
  output int n_ram,
  output int n_per,
  output logic [15:0] last_w,
  output logic [15:0] last_pa
);
  int pw;
  assign per_busy = busy_on;
  // data lines toggle when idle so a stale value never looks valid
  always @(posedge clock) begin
    if (sys_rst) begin
      ram_ready <= 1'b0;
      per_ready <= 1'b0;
      ram_rdata <= 16'h0000;
      per_rdata <= 16'h0000;
      n_ram <= 0;
      n_per <= 0;
      pw <= 0;
    end else begin
      if (ram_req && ram_ready) begin
        ram_ready <= 1'b0;
        n_ram <= n_ram + 1;
        ram_rdata <= ~ram_rdata;
        if (ram_we)
          last_w <= ram_wdata;
      end else begin
        ram_ready <= ram_req;
        ram_rdata <= ram_req ? ram_addr[15:0] ^ 16'ha5c3 : ~ram_rdata;
      end
      // a slow peripheral stalls so words queue up in the fifo without filling it
      if (per_req && per_ready) begin
        per_ready <= 1'b0;
        n_per <= n_per + 1;
        pw <= 0;
        last_pa <= per_addr;
        per_rdata <= ~per_rdata;
        if (per_we)
          last_w <= per_wdata;
      end else begin
        pw <= per_req ? pw + 1 : 0;
        per_ready <= per_req && pw >= (slow ? 6 : 0);
        per_rdata <= per_req ? per_addr ^ 16'h3c3c : ~per_rdata;
      end
    end
  end
endmodule

// ---- dca_top_test.sv ----
// self-checking bench of the dma channel block
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module dca_top_test;
  import dca_pkg::*;
  typedef struct {logic [1:0] ch; logic dir; logic [13:0] cnt;
    logic [23:0] sa; logic [15:0] pad; logic slow;} dca_row_t;
  logic clock, sys_rst, hsel, hwrite, hreadyout, hresp, slow, busy_on;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ram_req, ram_we, ram_ready, per_req, per_we, per_ready, per_busy;
  logic [23:0] ram_addr, ea;
  logic [15:0] ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
  logic [15:0] last_w, last_pa;
  logic [7:0] b;
  int n_ram, n_per, nr, np, errors, checks_done, cycles;
  dca_row_t r;
  dca_row_t rows [4] = '{'{2'd0, 1'b1, 14'h0000, 24'h012345, 16'h1111, 1'b0},
    '{2'd1, 1'b0, 14'h0003, 24'hab00fe, 16'h2222, 1'b1},
    '{2'd2, 1'b1, 14'h0014, 24'h00fff0, 16'h3333, 1'b1},
    '{2'd3, 1'b0, 14'h0001, 24'h7ffffe, 16'h4444, 1'b0}};
  logic [7:0] zero_regs [5] = '{8'h24, 8'h28, 8'h40, 8'h44, 8'h48};
  dca_top dca_top_i (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ready, .ram_rdata,
    .per_req, .per_we, .per_addr, .per_wdata, .per_ready, .per_busy,
    .per_rdata);
  dca_partner dca_partner_i (.clock, .sys_rst, .slow, .busy_on, .ram_req,
    .ram_we, .ram_addr, .ram_wdata, .ram_ready, .ram_rdata, .per_req,
    .per_we, .per_addr, .per_wdata, .per_ready, .per_busy, .per_rdata,
    .n_ram, .n_per, .last_w, .last_pa);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // one single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wait_idle(input logic [1:0] ch);
    logic [31:0] s;
    s = '0;
    while (s[ch] !== 1'b1 || s[4] !== 1'b0)
      ahb(1'b0, OFF_STAT, 32'h0, s);
  endtask
  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // a hang is cut short well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, slow, busy_on} <= '0;
    hsize <= 3'b010;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    do_reset();
    foreach (rows[i]) begin
      r = rows[i];
      b = {2'b00, r.ch, 4'h0};
      slow <= r.slow;
      nr = n_ram;
      np = n_per;
      // address and count only while the channel is still disabled
      ahb(1'b1, b + OFF_PAD, {16'h0, r.pad}, rd);
      ahb(1'b1, b + OFF_CNT, {16'h0, 2'b11, r.cnt}, rd);
      ahb(1'b1, b + OFF_BASE, {8'h0, r.sa}, rd);
      ahb(1'b1, b + OFF_CTRL, {30'h0, r.dir, 1'b1}, rd);
      wait_idle(r.ch);
      ea = r.sa + {10'h0, r.cnt};
      ahb(1'b0, b + OFF_CNT, 32'h0, rd);
      `CHK(rd, {18'h0, r.cnt})
      ahb(1'b0, b + OFF_PAD, 32'h0, rd);
      `CHK(rd, {16'h0, r.pad})
      `CHK(n_ram - nr, r.cnt + 1)
      `CHK(n_per - np, r.cnt + 1)
      ahb(1'b0, OFF_LAST_HI, 32'h0, rd);
      `CHK(rd, {24'h0, ea[23:16]})
      ahb(1'b0, OFF_LAST_LO, 32'h0, rd);
      `CHK(rd, {16'h0, ea[15:0]})
      `CHK(last_pa, r.pad)
      `CHK(last_w, r.dir ? ea[15:0] ^ 16'ha5c3 : r.pad ^ 16'h3c3c)
      $display("row %0d finished", i);
    end
    // collision: peripheral busy during a write, then cleared by control
    busy_on <= 1'b1;
    ahb(1'b1, 8'h18, 32'h0, rd);
    ahb(1'b1, 8'h10, 32'h3, rd);
    wait_idle(2'd1);
    ahb(1'b0, OFF_COLL, 32'h0, rd);
    `CHK(rd, 32'h2)
    busy_on <= 1'b0;
    ahb(1'b1, 8'h10, 32'h0, rd);
    ahb(1'b0, OFF_COLL, 32'h0, rd);
    `CHK(rd, 32'h0)
    $display("collision test finished");
    // read-only and unmapped places ignore writes
    ahb(1'b1, OFF_LAST_LO, 32'hffffffff, rd);
    ahb(1'b0, OFF_LAST_LO, 32'h0, rd);
    `CHK(rd, {16'h0, rows[1].sa[15:0]})
    ahb(1'b1, 8'h7c, 32'hffffffff, rd);
    ahb(1'b0, 8'h7c, 32'h0, rd);
    `CHK(rd, 32'h0)
    $display("read-only test finished");
    do_reset();
    foreach (zero_regs[i]) begin
      ahb(1'b0, zero_regs[i], 32'h0, rd);
      `CHK(rd, 32'h0)
    end
    $display("reset test finished");
    give_verdict();
  end
endmodule
